// ===== design/servo_torque_limit_gain_select.sv
// Torque limit selection, limit-reached status and gain tuning mode decode.
`timescale 1ns/1ps
`default_nettype none

module servo_torque_limit_gain_select #(
  parameter int ANALOG_W = 12,
  parameter int PINS     = 8
) (
  input  wire logic                clock,
  input  wire logic                rst_n,
  // Wishbone classic slave.
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  input  wire logic [3:0]          wb_sel_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Control connector inputs, low means shorted to signal common.
  input  wire logic [PINS-1:0]     input_pin_n,
  input  wire logic [ANALOG_W-1:0] analog_torque_limit_in,
  input  wire logic                servo_on_in,
  input  wire logic                speed_mode_in,
  input  wire logic                accel_active_in,
  input  wire logic [7:0]          torque_pct_in,
  input  wire logic [15:0]         inertia_estimate_in,
  input  wire logic [15:0]         auto_speed_gain_in,
  input  wire logic [15:0]         auto_integral_in,
  // Outputs toward the speed loop and the connector.
  output logic [7:0]               active_limit_out,
  output logic                     torque_limit_reached_out,
  output logic [15:0]              eff_speed_gain_out,
  output logic [15:0]              eff_integral_out,
  output logic [15:0]              eff_ff_gain_out,
  output logic                     compensator_en_out,
  output logic                     auto_tune_en_out,
  output logic                     gain_update_en_out
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  // Index field reaches eight pins.
  // The product fits in 24 bits.
  initial begin
    if (ANALOG_W < 8 || ANALOG_W > 16) begin
      $error("ANALOG_W must be 8 to 16");
    end
    if (PINS < 1 || PINS > 8) begin
      $error("PINS must be 1 to 8");
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // Plain flops, one strobe each.
  logic [15:0] tuning_mode_ff;
  logic [15:0] response_lvl_ff;
  logic [15:0] speed_gain_ff;
  logic [15:0] integral_time_ff;
  logic [15:0] ff_gain_ff;
  logic [7:0]  inner_first_ff;
  logic [7:0]  inner_second_ff;
  logic [7:0]  assign_ff;
  logic [7:0]  active_limit_ff;
  logic        reached_ff;
  logic        ack_ff;
  logic [31:0] rdata_ff;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  // A request is taken once; ack lasts one cycle and then drops.
  // Masking with ack_ff stops a held
  // request from being taken twice.
  wire req       = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wr        = req & wb_we_i;
  // Only lanes 0 and 1 carry data.
  wire lo_en     = wb_sel_i[0];
  wire hi_en     = wb_sel_i[1];
  // One compare per register offset.
  wire hit_mode  = wb_adr_i == torque_limit_pkg::OFS_TUNING_MODE;
  wire hit_resp  = wb_adr_i == torque_limit_pkg::OFS_RESPONSE_LVL;
  wire hit_gain  = wb_adr_i == torque_limit_pkg::OFS_SPEED_GAIN;
  wire hit_intg  = wb_adr_i == torque_limit_pkg::OFS_INTEGRAL_TIME;
  wire hit_ff    = wb_adr_i == torque_limit_pkg::OFS_FF_GAIN;
  wire hit_lim   = wb_adr_i == torque_limit_pkg::OFS_INNER_LIMITS;
  wire hit_asg   = wb_adr_i == torque_limit_pkg::OFS_INPUT_ASSIGN;
  wire hit_stat  = wb_adr_i == torque_limit_pkg::OFS_STATUS;
  wire hit_torq  = wb_adr_i == torque_limit_pkg::OFS_TORQUE;

  // Merge byte lanes into a 16-bit candidate for the halfword registers.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic        lo,
                                          input logic        hi);
    merge16 = {hi ? dat[15:8] : old[15:8], lo ? dat[7:0] : old[7:0]};
  endfunction

  // Checks see the merged value, so a
  // byte write cannot sneak past them.
  wire [15:0] cand_mode = merge16(tuning_mode_ff, wb_dat_i, lo_en, hi_en);
  wire [15:0] cand_resp = merge16(response_lvl_ff, wb_dat_i, lo_en, hi_en);
  wire [15:0] cand_gain = merge16(speed_gain_ff, wb_dat_i, lo_en, hi_en);
  wire [15:0] cand_intg = merge16(integral_time_ff, wb_dat_i, lo_en, hi_en);
  wire [15:0] cand_ff   = merge16(ff_gain_ff, wb_dat_i, lo_en, hi_en);
  // Limits take one lane each.
  wire [7:0]  cand_lim1 = lo_en ? wb_dat_i[7:0] : inner_first_ff;
  wire [7:0]  cand_lim2 = hi_en ? wb_dat_i[15:8] : inner_second_ff;

  // Out-of-range writes are ignored so the stored code is always legal.
  wire ok_mode = cand_mode <= torque_limit_pkg::MAX_TUNING_MODE;
  wire ok_resp = cand_resp >= torque_limit_pkg::MIN_RESPONSE_LVL &&
                 cand_resp <= torque_limit_pkg::MAX_RESPONSE_LVL;
  wire ok_ff   = cand_ff <= torque_limit_pkg::MAX_FF_GAIN;
  wire ok_lim1 = cand_lim1 <= torque_limit_pkg::MAX_INNER_LIMIT;
  wire ok_lim2 = cand_lim2 <= torque_limit_pkg::MAX_INNER_LIMIT;

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  // Settings keep their reset defaults until software writes a legal value.
  // Speed gain and integral time take any code as written.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tuning_mode_ff   <= torque_limit_pkg::RST_TUNING_MODE;
      response_lvl_ff  <= torque_limit_pkg::RST_RESPONSE_LVL;
      speed_gain_ff    <= torque_limit_pkg::RST_SPEED_GAIN;
      integral_time_ff <= torque_limit_pkg::RST_INTEGRAL_TIME;
      ff_gain_ff       <= torque_limit_pkg::RST_FF_GAIN;
      inner_first_ff   <= torque_limit_pkg::RST_INNER_LIMIT;
      inner_second_ff  <= torque_limit_pkg::RST_INNER_LIMIT;
      assign_ff        <= 8'h00;
    end else begin
      if (wr && hit_mode && ok_mode) tuning_mode_ff <= cand_mode;
      if (wr && hit_resp && ok_resp) response_lvl_ff <= cand_resp;
      if (wr && hit_gain) speed_gain_ff <= cand_gain;
      if (wr && hit_intg) integral_time_ff <= cand_intg;
      if (wr && hit_ff && ok_ff) ff_gain_ff <= cand_ff;
      if (wr && hit_lim && ok_lim1) inner_first_ff <= cand_lim1;
      if (wr && hit_lim && ok_lim2) inner_second_ff <= cand_lim2;
      if (wr && hit_asg && lo_en) assign_ff <= wb_dat_i[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // Selector inputs
  // --------------------------------------------------------------------------
  // Each selector has an enable bit and a pin index; an unassigned selector
  // reads inactive whatever its pin does.
  localparam int PIN_W = torque_limit_pkg::PIN_INDEX_W;
  wire [PIN_W-1:0] pin_a_idx = assign_ff[torque_limit_pkg::PIN_INDEX_W-1:0];
  wire [PIN_W-1:0] pin_b_idx =
    assign_ff[torque_limit_pkg::ASSIGN_B_LSB +: torque_limit_pkg::PIN_INDEX_W];
  // Bit 3 of each nibble enables it.
  wire en_a = assign_ff[torque_limit_pkg::ASSIGN_EN_BIT];
  wire en_b = assign_ff[torque_limit_pkg::ASSIGN_B_LSB +
                        torque_limit_pkg::ASSIGN_EN_BIT];
  // Missing pins read as open contacts.
  wire [PINS-1:0] pins_closed = ~input_pin_n;
  wire [7:0] pins_ext = ~8'(pins_closed);
  // A low pin means shorted to common.
  wire limit_select_a = en_a & ~pins_ext[pin_a_idx];
  wire limit_select_b = en_b & ~pins_ext[pin_b_idx];

  // --------------------------------------------------------------------------
  // Analog scaling and limit selection
  // --------------------------------------------------------------------------
  // Unsigned code, zero volts at zero, full scale at maximum torque; the
  // product fits 24 bits so the divide-free scale keeps timing short.
  // Code*100>>W stops at 99, so full
  // scale is forced to 100.
  wire [23:0] analog_prod = 24'(analog_torque_limit_in) * 24'(100);
  wire [23:0] analog_full = 24'((1 << ANALOG_W) - 1);
  wire [7:0]  analog_pct  = (analog_torque_limit_in == analog_full[ANALOG_W-1:0])
                            ? torque_limit_pkg::MAX_INNER_LIMIT
                            : 8'(analog_prod >> ANALOG_W);

  // The pair {b, a} is the enum code.
  torque_limit_pkg::limit_sel_e sel;
  assign sel = torque_limit_pkg::limit_sel_e'({limit_select_b, limit_select_a});

  // All minima are formed each cycle.
  wire [7:0] min_af = analog_pct < inner_first_ff ? analog_pct : inner_first_ff;
  wire [7:0] min_sf = inner_second_ff < inner_first_ff ? inner_second_ff
                                                       : inner_first_ff;
  wire [7:0] min_sa = inner_second_ff < analog_pct ? inner_second_ff
                                                   : analog_pct;

  logic [7:0] nxt_active_limit;
  // Four selector combinations pick the working limit.
  always_comb begin
    case (sel)
      torque_limit_pkg::SEL_INNER_FIRST:      nxt_active_limit = inner_first_ff;
      torque_limit_pkg::SEL_ANALOG_VS_FIRST:  nxt_active_limit = min_af;
      torque_limit_pkg::SEL_SECOND_VS_FIRST:  nxt_active_limit = min_sf;
      torque_limit_pkg::SEL_SECOND_VS_ANALOG: nxt_active_limit = min_sa;
      default:                                nxt_active_limit = inner_first_ff;
    endcase
  end

  // Reached compares against the already registered limit, so a selector
  // change shows on the status one cycle after it shows on the limit.
  wire nxt_reached = servo_on_in && (torque_pct_in >= active_limit_ff);

  // Limit and flag share one reset.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active_limit_ff <= torque_limit_pkg::RST_INNER_LIMIT;
      reached_ff      <= 1'b0;
    end else begin
      active_limit_ff <= nxt_active_limit;
      reached_ff      <= nxt_reached;
    end
  end

  // Servo-off drops the pin at once.
  assign active_limit_out         = active_limit_ff;
  assign torque_limit_reached_out = reached_ff & servo_on_in;

  // --------------------------------------------------------------------------
  // Gain tuning mode decode
  // --------------------------------------------------------------------------
  // Writes above 3 fail, so bits 15:2 stay 0.
  wire [1:0] mode_code = tuning_mode_ff[1:0];
  // Codes 0 and 1 are manual; 2 and 3 tune.
  wire manual = (mode_code == torque_limit_pkg::MODE_MANUAL) ||
                (mode_code == torque_limit_pkg::MODE_MANUAL_COMP);
  // Compensator is blind to inertia ratio; avoiding it above ten is on software.
  assign compensator_en_out = mode_code == torque_limit_pkg::MODE_MANUAL_COMP;
  assign auto_tune_en_out   = ~manual;
  assign gain_update_en_out = ~manual & accel_active_in;
  // Effective gains: stored values in manual, tracked values in automatic; feed-forward is the stored value in manual speed mode, else zero.
  assign eff_speed_gain_out = manual ? speed_gain_ff : auto_speed_gain_in;
  assign eff_integral_out   = manual ? integral_time_ff : auto_integral_in;
  assign eff_ff_gain_out    = (manual && speed_mode_in) ? ff_gain_ff : 16'h0000;

  // --------------------------------------------------------------------------
  // Read data and ack
  // --------------------------------------------------------------------------
  // Status bit 8 skips the output gate.
  wire [31:0] stat_word = {16'h0000, 4'h0, 1'b0, compensator_en_out,
                           auto_tune_en_out, reached_ff,
                           6'h00, limit_select_b, limit_select_a};
  // Offsets never overlap.
  wire [31:0] rd_mux =
      hit_mode ? {16'h0000, tuning_mode_ff} :
      hit_resp ? {16'h0000, response_lvl_ff} :
      hit_gain ? {16'h0000, speed_gain_ff} :
      hit_intg ? {16'h0000, integral_time_ff} :
      hit_ff   ? {16'h0000, ff_gain_ff} :
      hit_lim  ? {16'h0000, inner_second_ff, inner_first_ff} :
      hit_asg  ? {24'h0000_00, assign_ff} :
      hit_stat ? stat_word :
      hit_torq ? {inertia_estimate_in, 8'h00, active_limit_ff} :
                 32'h0000_0000;

  // Unmapped addresses answer with ack and zero data.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff   <= req;
      rdata_ff <= req ? rd_mux : rdata_ff;
    end
  end

  // Ack and data come from flops.
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  // One domain: shared clock, disable.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // One property per selector pair.
  idle_limit_a: assert property (!limit_select_a && !limit_select_b |=>
    active_limit_ff == $past(inner_first_ff)) else $error("idle limit wrong");
  analog_min_a: assert property (limit_select_a && !limit_select_b |=>
    active_limit_ff <= $past(inner_first_ff) &&
    active_limit_ff <= $past(analog_pct)) else $error("analog min wrong");
  second_min_a: assert property (!limit_select_a && limit_select_b |=>
    active_limit_ff <= $past(inner_first_ff) &&
    active_limit_ff <= $past(inner_second_ff)) else $error("second min wrong");
  both_min_a: assert property (limit_select_a && limit_select_b |=>
    active_limit_ff <= $past(analog_pct) &&
    active_limit_ff <= $past(inner_second_ff)) else $error("both min wrong");
  // Reached flag and its servo gate.
  reached_off_a: assert property (!servo_on_in |->
    !torque_limit_reached_out) else $error("reached while servo off");
  reached_set_a: assert property (servo_on_in &&
    torque_pct_in >= active_limit_ff ##1 servo_on_in |->
    torque_limit_reached_out) else $error("reached missed");
  // Stored codes stay legal.
  mode_range_a: assert property (tuning_mode_ff <=
    torque_limit_pkg::MAX_TUNING_MODE) else $error("mode out of range");
  resp_range_a: assert property (response_lvl_ff != 16'h0000 &&
    response_lvl_ff <= torque_limit_pkg::MAX_RESPONSE_LVL)
    else $error("response out of range");
  // Compensator only in manual mode.
  comp_mode_a: assert property (compensator_en_out |->
    !auto_tune_en_out && eff_speed_gain_out == speed_gain_ff)
    else $error("compensator outside manual");
  // Bus handshake.
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  // A taken request is answered next cycle.
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o) else $error("no ack");
  // Reached clears once torque is below.
  reached_clr_a: assert property (torque_pct_in < active_limit_ff |=>
    !torque_limit_reached_out) else $error("reached stuck");
  // Manual codes route the stored gains.
  manual_gain_a: assert property (manual |->
    eff_speed_gain_out == speed_gain_ff &&
    eff_integral_out == integral_time_ff) else $error("gains lost");
  // Feed-forward is silent outside speed mode.
  ff_gate_a: assert property (!speed_mode_in |->
    eff_ff_gain_out == 16'h0000) else $error("ff leaks");
  // Updates run only while accelerating.
  upd_gate_a: assert property (gain_update_en_out |->
    auto_tune_en_out && accel_active_in) else $error("bad update");
  // Stored limits stay within percent.
  lim_range_a: assert property (inner_first_ff <=
    torque_limit_pkg::MAX_INNER_LIMIT &&
    inner_second_ff <= torque_limit_pkg::MAX_INNER_LIMIT)
    else $error("limit range");
  // Full scale analog means full torque.
  full_scale_a: assert property (
    analog_torque_limit_in == analog_full[ANALOG_W-1:0] |->
    analog_pct == torque_limit_pkg::MAX_INNER_LIMIT)
    else $error("full scale");

  sel_both_c: cover property (limit_select_a && limit_select_b ##1
    torque_limit_reached_out);
  comp_on_c: cover property (compensator_en_out);
  auto_upd_c: cover property (gain_update_en_out);
  // Covers for manual gains and servo drop.
  manual_ff_c: cover property (mode_code == torque_limit_pkg::MODE_MANUAL &&
    speed_mode_in);
  servo_drop_c: cover property (reached_ff && !servo_on_in);

endmodule

`default_nettype wire

// ===== design/torque_limit_pkg.sv
// Package with register map, field layouts and reset values for the torque limit block.
package torque_limit_pkg;

  // --------------------------------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFS_TUNING_MODE   = 8'h00;
  localparam logic [7:0] OFS_RESPONSE_LVL  = 8'h04;
  localparam logic [7:0] OFS_SPEED_GAIN    = 8'h08;
  localparam logic [7:0] OFS_INTEGRAL_TIME = 8'h0C;
  localparam logic [7:0] OFS_FF_GAIN       = 8'h10;
  localparam logic [7:0] OFS_INNER_LIMITS  = 8'h14;
  localparam logic [7:0] OFS_INPUT_ASSIGN  = 8'h18;
  localparam logic [7:0] OFS_STATUS        = 8'h1C;
  localparam logic [7:0] OFS_TORQUE        = 8'h20;

  // --------------------------------------------------------------------------
  // Reset values and allowed ranges
  // --------------------------------------------------------------------------
  localparam logic [15:0] RST_TUNING_MODE   = 16'h0002;
  localparam logic [15:0] MAX_TUNING_MODE   = 16'h0003;
  localparam logic [15:0] RST_RESPONSE_LVL  = 16'h0005;
  localparam logic [15:0] MIN_RESPONSE_LVL  = 16'h0001;
  localparam logic [15:0] MAX_RESPONSE_LVL  = 16'h000F;
  localparam logic [15:0] RST_SPEED_GAIN    = 16'h0331;
  localparam logic [15:0] RST_INTEGRAL_TIME = 16'h0030;
  localparam logic [15:0] RST_FF_GAIN       = 16'h0000;
  localparam logic [15:0] MAX_FF_GAIN       = 16'h4E20;
  localparam logic [7:0]  RST_INNER_LIMIT   = 8'h64;
  localparam logic [7:0]  MAX_INNER_LIMIT   = 8'h64;

  // --------------------------------------------------------------------------
  // Tuning mode codes and field positions
  // --------------------------------------------------------------------------
  localparam logic [1:0] MODE_MANUAL       = 2'h0;
  localparam logic [1:0] MODE_MANUAL_COMP  = 2'h1;
  localparam int INNER_SECOND_LSB = 8;
  localparam int ASSIGN_B_LSB     = 4;
  localparam int PIN_INDEX_W      = 3;
  localparam int ASSIGN_EN_BIT    = 3;

  // Selector state, decoded from the pair of selector inputs.
  typedef enum logic [1:0] {
    SEL_INNER_FIRST,
    SEL_ANALOG_VS_FIRST,
    SEL_SECOND_VS_FIRST,
    SEL_SECOND_VS_ANALOG
  } limit_sel_e;

endpackage

// ===== dv/host_ctrl_model.sv
// Host controller model that drives the selector pins and the analog limit.
`timescale 1ns/1ps
`default_nettype none

module host_ctrl_model #(
  parameter int PINS     = 8,
  parameter int ANALOG_W = 12
) (
  input  wire logic                short_a,
  input  wire logic                short_b,
  input  wire logic [2:0]          pin_a,
  input  wire logic [2:0]          pin_b,
  input  wire logic [ANALOG_W-1:0] level,
  output logic      [PINS-1:0]     input_pin_n,
  output logic      [ANALOG_W-1:0] analog_torque_limit_in
);
  // --------------------------------------------------------------------------
  // Contact and voltage drive
  // --------------------------------------------------------------------------
  // An open contact floats to the pull-up, so only a shorted pin reads low.
  // Commands arrive just after a rising edge, so the pins move there too.
  always_comb begin
    input_pin_n = '1;
    if (short_a) begin
      input_pin_n[pin_a] = 1'b0;
    end
    if (short_b) begin
      input_pin_n[pin_b] = 1'b0;
    end
    analog_torque_limit_in = level;
  end
endmodule

`default_nettype wire

// ===== dv/test_servo_torque_limit_gain_select.sv
// Self-checking bench for the torque limit and gain select block.
`timescale 1ns/1ps
`default_nettype none

module test_servo_torque_limit_gain_select;
  logic        clock;
  logic        rst_n;
  logic        cyc;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] dat_o;
  logic        ack;
  logic [7:0]  pins_n;
  logic [11:0] analog;
  logic        servo_on;
  logic        speed_mode;
  logic        accel;
  logic [7:0]  torque;
  logic        short_a;
  logic        short_b;
  logic [11:0] level;
  logic [7:0]  limit;
  logic        reached;
  logic        comp_en;
  logic        auto_en;
  logic        upd_en;
  logic [15:0] sgain;
  logic [15:0] igain;
  logic [15:0] fgain;
  logic [31:0] rd;
  logic [3:0]  sel;
  int          mismatches;
  int          comparisons;

  // --------------------------------------------------------------------------
  // Block and host model
  // --------------------------------------------------------------------------
  servo_torque_limit_gain_select dut (
    .clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .input_pin_n(pins_n),
    .analog_torque_limit_in(analog), .servo_on_in(servo_on),
    .speed_mode_in(speed_mode), .accel_active_in(accel),
    .torque_pct_in(torque), .inertia_estimate_in(16'h1234),
    .auto_speed_gain_in(16'h0abc), .auto_integral_in(16'h0def),
    .active_limit_out(limit), .torque_limit_reached_out(reached),
    .eff_speed_gain_out(sgain), .eff_integral_out(igain),
    .eff_ff_gain_out(fgain), .compensator_en_out(comp_en),
    .auto_tune_en_out(auto_en), .gain_update_en_out(upd_en));

  host_ctrl_model host (
    .short_a(short_a), .short_b(short_b), .pin_a(3'd2), .pin_b(3'd5),
    .level(level), .input_pin_n(pins_n), .analog_torque_limit_in(analog));

  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  // Compares one value and keeps the tallies.
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Prints the verdict and stops the run.
  task automatic end_of_test();
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One classic cycle; held until ack is seen, then one idle cycle.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0;
    if (ack !== 1'b1) begin
      chk("ack", 32'h0000_0001, {31'h0, ack});
      end_of_test();
    end
    @(posedge clock);
  endtask

  // Reads a register and compares its low half.
  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [15:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(n, {16'h0, e}, {16'h0, rd[15:0]});
  endtask

  // Gives the registered limit and status path time to land.
  task automatic settle();
    repeat (4) @(posedge clock);
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset();
    rchk("mode", torque_limit_pkg::OFS_TUNING_MODE, 16'h0002);
    rchk("resp", torque_limit_pkg::OFS_RESPONSE_LVL, 16'h0005);
    rchk("vg", torque_limit_pkg::OFS_SPEED_GAIN, 16'h0331);
    rchk("vi", torque_limit_pkg::OFS_INTEGRAL_TIME, 16'h0030);
    rchk("ff", torque_limit_pkg::OFS_FF_GAIN, 16'h0000);
    rchk("lims", torque_limit_pkg::OFS_INNER_LIMITS, 16'h6464);
    chk("auto_en", 32'h0000_0001, {31'h0, auto_en});
    chk("limit", 32'h0000_0064, {24'h0, limit});
  endtask

  // Out-of-range writes are dropped whole; boundary values are kept.
  task automatic t_range();
    wb(1'b1, torque_limit_pkg::OFS_TUNING_MODE, 32'h0000_0004);
    rchk("mode_hi", torque_limit_pkg::OFS_TUNING_MODE, 16'h0002);
    wb(1'b1, torque_limit_pkg::OFS_RESPONSE_LVL, 32'h0000_0000);
    wb(1'b1, torque_limit_pkg::OFS_RESPONSE_LVL, 32'h0000_0010);
    rchk("resp_out", torque_limit_pkg::OFS_RESPONSE_LVL, 16'h0005);
    wb(1'b1, torque_limit_pkg::OFS_RESPONSE_LVL, 32'h0000_000f);
    rchk("resp_max", torque_limit_pkg::OFS_RESPONSE_LVL, 16'h000f);
    wb(1'b1, torque_limit_pkg::OFS_FF_GAIN, 32'h0000_4e21);
    rchk("ff_hi", torque_limit_pkg::OFS_FF_GAIN, 16'h0000);
    wb(1'b1, torque_limit_pkg::OFS_FF_GAIN, 32'h0000_4e20);
    rchk("ff_max", torque_limit_pkg::OFS_FF_GAIN, 16'h4e20);
    wb(1'b1, torque_limit_pkg::OFS_INNER_LIMITS, 32'h0000_6565);
    rchk("lim_hi", torque_limit_pkg::OFS_INNER_LIMITS, 16'h6464);
    sel <= 4'h1;
    wb(1'b1, torque_limit_pkg::OFS_INNER_LIMITS, 32'h0000_0a28);
    sel <= 4'h3;
    rchk("lane", torque_limit_pkg::OFS_INNER_LIMITS, 16'h6428);
    wb(1'b0, 8'h3c, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
  endtask

  // Every tuning code, with the motor accelerating in speed mode.
  task automatic t_modes();
    logic man;
    wb(1'b1, torque_limit_pkg::OFS_SPEED_GAIN, 32'h0000_0100);
    wb(1'b1, torque_limit_pkg::OFS_INTEGRAL_TIME, 32'h0000_0020);
    speed_mode <= 1'b1;
    accel      <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      man = (m < 2);
      wb(1'b1, torque_limit_pkg::OFS_TUNING_MODE, m);
      chk("comp", {31'h0, m == 1}, {31'h0, comp_en});
      chk("auto", {31'h0, !man}, {31'h0, auto_en});
      chk("upd", {31'h0, !man}, {31'h0, upd_en});
      chk("vg", man ? 32'h0000_0100 : 32'h0000_0abc, {16'h0, sgain});
      chk("vi", man ? 32'h0000_0020 : 32'h0000_0def, {16'h0, igain});
      if (man) begin
        chk("ff", 32'h0000_4e20, {16'h0, fgain});
      end
    end
    accel <= 1'b0;
    settle();
    chk("upd_idle", 32'h0000_0000, {31'h0, upd_en});
    wb(1'b1, torque_limit_pkg::OFS_TUNING_MODE, 32'h0000_0000);
    speed_mode <= 1'b0;
    settle();
    chk("ff_pos", 32'h0000_0000, {16'h0, fgain});
  endtask

  // All selector pairs: first 60, second 55, analog half scale (50).
  task automatic t_select();
    logic [7:0] exp [4];
    exp = '{8'h3c, 8'h32, 8'h37, 8'h32};
    wb(1'b1, torque_limit_pkg::OFS_INNER_LIMITS, 32'h0000_373c);
    wb(1'b1, torque_limit_pkg::OFS_INPUT_ASSIGN, 32'h0000_00da);
    level <= 12'h800;
    for (int i = 0; i < 4; i++) begin
      short_a <= i[0];
      short_b <= i[1];
      settle();
      chk("sel_limit", {24'h0, exp[i]}, {24'h0, limit});
    end
    wb(1'b1, torque_limit_pkg::OFS_INNER_LIMITS, 32'h0000_3764);
    short_b <= 1'b0;
    level   <= 12'hfff;
    settle();
    chk("full_scale", 32'h0000_0064, {24'h0, limit});
    wb(1'b0, torque_limit_pkg::OFS_TORQUE, 32'h0000_0000);
    chk("readback", 32'h1234_0064, {rd[31:16], 8'h0, rd[7:0]});
    level <= 12'h800;
    wb(1'b1, torque_limit_pkg::OFS_INPUT_ASSIGN, 32'h0000_0052);
    settle();
    chk("unassigned", 32'h0000_0064, {24'h0, limit});
  endtask

  // Limit-reached at the exact limit, and gated by servo-on.
  task automatic t_reached();
    wb(1'b1, torque_limit_pkg::OFS_INNER_LIMITS, 32'h0000_373c);
    short_a  <= 1'b0;
    servo_on <= 1'b1;
    torque   <= 8'h3b;
    settle();
    chk("below", 32'h0000_0000, {31'h0, reached});
    torque <= 8'h3c;
    settle();
    chk("at_limit", 32'h0000_0001, {31'h0, reached});
    servo_on <= 1'b0;
    settle();
    chk("servo_off", 32'h0000_0000, {31'h0, reached});
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    mismatches  = 0;
    comparisons = 0;
    rst_n       = 1'b0;
    cyc         = 1'b0;
    we          = 1'b0;
    adr         = 8'h00;
    wdat        = 32'h0000_0000;
    servo_on    = 1'b0;
    speed_mode  = 1'b0;
    accel       = 1'b0;
    torque      = 8'h00;
    short_a     = 1'b0;
    short_b     = 1'b0;
    level       = 12'h000;
    sel         = 4'h3;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_range();
    t_modes();
    t_select();
    t_reached();
    end_of_test();
  end
endmodule

`default_nettype wire
